// >>> ias_seq.sv
// Notes on behaviour
// RQ1 - Ack enable pulls clock low and drives the stored ack data value.
// RQ2 - Software sets ack data value before starting the ack sequence.
// RQ3 - After one rollover period with ack presented, the clock line is released.
// RQ4 - Once clock is seen high, time one more period, then pull clock low.
// RQ5 - At ack end, clear ack enable, stop the counter, go idle.
// RQ6 - Buffer writes during an ack sequence are dropped and flag a collision.
// RQ7 - After the ninth falling clock edge of a byte, hold clock low.
// RQ8 - Stop enable pulls data low; once seen low the counter reloads and runs.
// RQ9 - On timeout release clock; once clock is seen high, time one period, then release data.
// RQ10 - Data seen high while clock high sets the stop-detected flag.
// RQ11 - One period after stop detection clear stop enable and raise interrupt flag.
// RQ12 - Buffer writes during a stop sequence are dropped and flag a collision.
// RQ13 - Lines are only pulled low or released, never driven high.
`include "ias_map.svh"
`timescale 1ns/1ns
module ias_seq #(
  parameter int BAUD_W = 8
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Byte engine strobe at the ninth falling clock edge.
  input wire logic byte_done,
  // Serial clock pin.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  // Serial data pin.
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Interrupt.
  output logic irq
);

  generate
    if (BAUD_W < 2 || BAUD_W > 8) begin : g_chk
      $error("ias_seq: BAUD_W must be 2 to 8");
    end
  endgenerate

  // Pin synchronisers: a change counts once the second and third stages agree.
  logic [1:0] pin_raw;
  logic [1:0] pin_f;
  logic scl_f;
  logic sda_f;

  assign pin_raw = {sda_in, scl_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      // Each pin keeps its stages in its own variables so every flop has one writer.
      logic [2:0] stage;
      logic filt;
      logic next_f;
      always_comb begin
        next_f = (stage[1] == stage[2]) ? stage[2] : filt;
      end
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          stage <= 3'h7;
          filt <= 1'b1;
        end else begin
          stage <= {stage[1:0], pin_raw[gi]};
          filt <= next_f;
        end
      end
      assign pin_f[gi] = filt;
    end
  endgenerate

  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];

  // Bus front end.
  logic wr_pend;
  logic rd_pend;
  logic rd_wait;
  logic [7:0] dp_addr;
  logic next_wr_pend;
  logic next_rd_pend;
  logic next_rd_wait;
  logic [7:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic addr_ok;

  // Software registers.
  logic ack_data_value;
  logic [BAUD_W-1:0] baud;
  logic [7:0] buf_q;
  logic [`IAS_IRQ_W-1:0] irq_st;
  logic [`IAS_IRQ_W-1:0] irq_mask;
  logic next_ack_data_value;
  logic [BAUD_W-1:0] next_baud;
  logic [7:0] next_buf_q;
  logic [`IAS_IRQ_W-1:0] next_irq_st;
  logic [`IAS_IRQ_W-1:0] next_irq_mask;
  logic wr_ctrl;
  logic wr_buf;
  logic rd_irq;
  logic [`IAS_IRQ_W-1:0] irq_ev;

  // Sequencer.
  ias_pkg::ias_state_t state;
  ias_pkg::ias_state_t next_state;
  logic ack_sequence_enable;
  logic stop_sequence_enable;
  logic p_flag;
  logic scl_low;
  logic sda_low;
  logic next_ack_sequence_enable;
  logic next_pen;
  logic next_p_flag;
  logic next_scl_low;
  logic next_sda_low;
  logic seq_done;
  logic stop_seen;
  logic busy;
  logic run;
  logic tick;
  logic start_ack;
  logic start_stop;

  assign busy = (state != ias_pkg::IAS_IDLE);

  // Reads take one wait state so that read data always come from a register.
  assign hreadyout = !rd_wait;
  assign hresp = 1'b0;
  assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

  always_comb begin
    next_wr_pend = wr_pend;
    next_rd_pend = 1'b0;
    next_rd_wait = 1'b0;
    next_dp_addr = dp_addr;
    next_hrdata = hrdata;
    if (hready) begin
      next_wr_pend = hsel && htrans[1] && hwrite && addr_ok;
      next_rd_pend = hsel && htrans[1] && !hwrite;
      next_rd_wait = next_rd_pend;
      next_dp_addr = addr_ok ? haddr[7:0] : 8'hFF;
    end
    if (rd_pend) begin
      next_wr_pend = 1'b0;
      unique case (dp_addr)
        `IAS_OFF_CTRL: next_hrdata = {29'h0, ack_data_value, stop_sequence_enable, ack_sequence_enable};
        `IAS_OFF_BAUD: next_hrdata = {{(32-BAUD_W){1'b0}}, baud};
        `IAS_OFF_BUF: next_hrdata = {24'h0, buf_q};
        `IAS_OFF_STAT: next_hrdata = {28'h0, busy, sda_f, scl_f, p_flag};
        `IAS_OFF_IRQ: next_hrdata = {29'h0, irq_st};
        `IAS_OFF_MASK: next_hrdata = {29'h0, irq_mask};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      rd_wait <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      rd_wait <= next_rd_wait;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
    end
  end

  assign wr_ctrl = wr_pend && (dp_addr == `IAS_OFF_CTRL);
  assign wr_buf = wr_pend && (dp_addr == `IAS_OFF_BUF);
  assign rd_irq = rd_pend && (dp_addr == `IAS_OFF_IRQ);

  // A new sequence is only accepted while idle; ack wins when both bits are written.
  assign start_ack = wr_ctrl && hwdata[`IAS_CTRL_ACK_SEQUENCE_ENABLE] && !busy;
  assign start_stop = wr_ctrl && hwdata[`IAS_CTRL_PEN] && !busy && !hwdata[`IAS_CTRL_ACK_SEQUENCE_ENABLE];

  always_comb begin
    irq_ev = '0;
    irq_ev[`IAS_IRQ_DONE] = seq_done; // RQ11
    irq_ev[`IAS_IRQ_WRITE_COLLISION_FLAG] = wr_buf && busy; // RQ6 RQ12
    irq_ev[`IAS_IRQ_STOP] = stop_seen;
  end

  always_comb begin
    next_ack_data_value = ack_data_value;
    next_baud = baud;
    next_buf_q = buf_q;
    next_irq_mask = irq_mask;
    next_irq_st = irq_st;
    if (wr_ctrl) begin
      next_ack_data_value = hwdata[`IAS_CTRL_ACK_DATA_VALUE];
    end
    if (wr_pend && dp_addr == `IAS_OFF_BAUD) begin
      next_baud = hwdata[BAUD_W-1:0];
    end
    // A buffer write while a sequence runs leaves the buffer untouched.
    if (wr_buf && !busy) begin
      next_buf_q = hwdata[7:0]; // RQ6 RQ12
    end
    if (wr_pend && dp_addr == `IAS_OFF_MASK) begin
      next_irq_mask = hwdata[`IAS_IRQ_W-1:0];
    end
    // Read clears, but an event in the same cycle survives the clear.
    if (rd_irq) begin
      next_irq_st = '0;
    end
    next_irq_st = next_irq_st | irq_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_data_value <= 1'b0;
      baud <= BAUD_W'(`IAS_RST_BAUD);
      buf_q <= `IAS_RST_BUF;
      irq_mask <= `IAS_RST_MASK;
      irq_st <= '0;
    end else begin
      ack_data_value <= next_ack_data_value;
      baud <= next_baud;
      buf_q <= next_buf_q;
      irq_mask <= next_irq_mask;
      irq_st <= next_irq_st;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_irq_st & next_irq_mask);
    end
  end

  // Rollover timer; it runs only in the timed states and is otherwise off.
  always_comb begin
    unique case (state)
      ias_pkg::IAS_ACK_LOW,
      ias_pkg::IAS_ACK_HIGH,
      ias_pkg::IAS_STP_CNT,
      ias_pkg::IAS_STP_SCLH,
      ias_pkg::IAS_STP_FIN: run = 1'b1;
      default: run = 1'b0;
    endcase
  end

  ias_baud #(
    .W(BAUD_W)
  ) u_baud (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .reload(baud),
    .tick(tick)
  );

  always_comb begin
    next_state = state;
    next_ack_sequence_enable = ack_sequence_enable;
    next_pen = stop_sequence_enable;
    next_p_flag = p_flag;
    next_scl_low = scl_low;
    next_sda_low = sda_low;
    seq_done = 1'b0;
    stop_seen = 1'b0;
    unique case (state)
      ias_pkg::IAS_IDLE: begin
        if (byte_done) begin
          next_scl_low = 1'b1; // RQ7
        end
        if (start_ack) begin
          next_state = ias_pkg::IAS_ACK_LOW;
          next_ack_sequence_enable = 1'b1;
          next_scl_low = 1'b1; // RQ1
          next_sda_low = !hwdata[`IAS_CTRL_ACK_DATA_VALUE]; // RQ1
        end else if (start_stop) begin
          next_state = ias_pkg::IAS_STP_SDA;
          next_pen = 1'b1;
          next_p_flag = 1'b0;
          next_scl_low = 1'b1;
          next_sda_low = 1'b1; // RQ8
        end
      end
      ias_pkg::IAS_ACK_LOW: begin
        if (tick) begin
          next_scl_low = 1'b0; // RQ3
          next_state = ias_pkg::IAS_ACK_REL;
        end
      end
      ias_pkg::IAS_ACK_REL: begin
        // A target stretching the clock holds us here.
        if (scl_f) begin
          next_state = ias_pkg::IAS_ACK_HIGH; // RQ4
        end
      end
      ias_pkg::IAS_ACK_HIGH: begin
        if (tick) begin
          next_scl_low = 1'b1; // RQ4
          next_sda_low = 1'b0;
          next_ack_sequence_enable = 1'b0; // RQ5
          seq_done = 1'b1;
          next_state = ias_pkg::IAS_IDLE; // RQ5
        end
      end
      ias_pkg::IAS_STP_SDA: begin
        if (!sda_f) begin
          next_state = ias_pkg::IAS_STP_CNT; // RQ8
        end
      end
      ias_pkg::IAS_STP_CNT: begin
        if (tick) begin
          next_scl_low = 1'b0; // RQ9
          next_state = ias_pkg::IAS_STP_SCL;
        end
      end
      ias_pkg::IAS_STP_SCL: begin
        if (scl_f) begin
          next_state = ias_pkg::IAS_STP_SCLH;
        end
      end
      ias_pkg::IAS_STP_SCLH: begin
        if (tick) begin
          next_sda_low = 1'b0; // RQ9
          next_state = ias_pkg::IAS_STP_DET;
        end
      end
      ias_pkg::IAS_STP_DET: begin
        if (sda_f && scl_f) begin
          next_p_flag = 1'b1; // RQ10
          stop_seen = 1'b1;
          next_state = ias_pkg::IAS_STP_FIN;
        end
      end
      ias_pkg::IAS_STP_FIN: begin
        if (tick) begin
          next_pen = 1'b0; // RQ11
          seq_done = 1'b1; // RQ11
          next_state = ias_pkg::IAS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ias_pkg::IAS_IDLE;
      ack_sequence_enable <= 1'b0;
      stop_sequence_enable <= 1'b0;
      p_flag <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else begin
      state <= next_state;
      ack_sequence_enable <= next_ack_sequence_enable;
      stop_sequence_enable <= next_pen;
      p_flag <= next_p_flag;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
    end
  end

  // Open-drain drive: the pad only ever pulls low, release leaves it to the pull-up.
  assign scl_out = 1'b0; // RQ13
  assign sda_out = 1'b0; // RQ13
  assign scl_oe_n = !scl_low; // RQ13
  assign sda_oe_n = !sda_low; // RQ13

  // Transfer size is not checked; only whole-word singles are expected.
  logic unused_ok;
  assign unused_ok = ^{hsize, hwdata[31:8]};

endmodule

// >>> ias_map.svh
`ifndef IAS_MAP_SVH
`define IAS_MAP_SVH

// Register byte offsets.
`define IAS_OFF_CTRL 8'h00
`define IAS_OFF_BAUD 8'h04
`define IAS_OFF_BUF 8'h08
`define IAS_OFF_STAT 8'h0C
`define IAS_OFF_IRQ 8'h10
`define IAS_OFF_MASK 8'h14

// Control register fields.
`define IAS_CTRL_ACK_SEQUENCE_ENABLE 0
`define IAS_CTRL_PEN 1
`define IAS_CTRL_ACK_DATA_VALUE 2

// Status register fields.
`define IAS_STAT_P 0
`define IAS_STAT_SCL 1
`define IAS_STAT_SDA 2
`define IAS_STAT_BUSY 3

// Interrupt status and mask fields.
`define IAS_IRQ_DONE 0
`define IAS_IRQ_WRITE_COLLISION_FLAG 1
`define IAS_IRQ_STOP 2
`define IAS_IRQ_W 3

// Reset values.
`define IAS_RST_BAUD 8'h09
`define IAS_RST_MASK 3'h0
`define IAS_RST_BUF 8'h00

`endif

// >>> ias_pkg.sv
package ias_pkg;

  typedef enum logic [3:0] {
    IAS_IDLE,
    IAS_ACK_LOW,
    IAS_ACK_REL,
    IAS_ACK_HIGH,
    IAS_STP_SDA,
    IAS_STP_CNT,
    IAS_STP_SCL,
    IAS_STP_SCLH,
    IAS_STP_DET,
    IAS_STP_FIN
  } ias_state_t;

endpackage

// >>> ias_baud.sv
`timescale 1ns/1ns
module ias_baud #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Control.
  input wire logic run,
  input wire logic [W-1:0] reload,
  // Rollover enable.
  output logic tick
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  generate
    if (W < 2 || W > 16) begin : g_chk
      $error("ias_baud: W must be 2 to 16");
    end
  endgenerate

  // While stopped the counter sits at the reload value, so each run starts a full period.
  always_comb begin
    tick = run && (count == '0);
    if (!run) begin
      next_count = reload;
    end else if (count == '0) begin
      next_count = reload;
    end else begin
      next_count = count - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule

// >>> ias_seq_asserts.sv
`timescale 1ns/1ns
`include "ias_map.svh"
module ias_seq_asserts (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Serial side.
  input wire logic byte_done,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  // Carries a control write from its address phase into its data phase.
  logic ctrl_wr;
  logic next_ctrl_wr;
  always_comb begin
    next_ctrl_wr = hready ? (hsel && htrans[1] && hwrite && haddr == 32'h0) : ctrl_wr;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wr <= 1'b0;
    end else begin
      ctrl_wr <= next_ctrl_wr;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence ack_go;
    ctrl_wr && hready && hwdata[`IAS_CTRL_ACK_SEQUENCE_ENABLE];
  endsequence
  sequence stop_go;
    ctrl_wr && hready && hwdata[`IAS_CTRL_PEN] && !hwdata[`IAS_CTRL_ACK_SEQUENCE_ENABLE];
  endsequence
  a_never_high: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("line driven high");
  a_ack_start: assert property (ack_go |=> !scl_oe_n && sda_oe_n == $past(hwdata[2]))
    else $error("ack start wrong");
  a_stop_start: assert property (stop_go |=> !scl_oe_n && !sda_oe_n)
    else $error("stop start wrong");
  a_low_period: assert property ($rose(scl_oe_n) |-> !$past(scl_oe_n, 2))
    else $error("clock released early");
  a_arb_hold: assert property (scl_oe_n && !scl_in && !byte_done |=> scl_oe_n)
    else $error("clock pulled while held low");
  a_pull_after: assert property ($fell(scl_oe_n) |-> $past(scl_in))
    else $error("clock pulled before seen high");
  a_byte_hold: assert property ($rose(byte_done) |-> ##[1:3] !scl_oe_n)
    else $error("clock not held after byte");
  a_data_release: assert property ($rose(sda_oe_n) && scl_oe_n |-> $past(scl_oe_n, 3))
    else $error("data released too soon");
endmodule
bind ias_seq ias_seq_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .byte_done(byte_done),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// >>> ias_i2c_target.sv
`timescale 1ns/1ns
module ias_i2c_target (
  // Enables from the sequencer.
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  // Clock stretch request.
  input wire logic stretch,
  // Wire levels.
  output logic scl_in,
  output logic sda_in
);
  // Pull-ups make a released line high; a stretching target beats them.
  assign scl_in = scl_oe_n && !stretch;
  assign sda_in = sda_oe_n;
endmodule

// >>> ias_seq_tb.sv
`timescale 1ns/1ns
`include "ias_map.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ias_seq_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic byte_done = 1'b0;
  logic stretch = 1'b0;
  logic hreadyout, hresp, scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n, irq;
  logic [31:0] hrdata;
  logic [31:0] rv;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #4 hclk = ~hclk;
  ias_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .byte_done(byte_done),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq(irq));
  ias_i2c_target far (.scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .stretch(stretch),
    .scl_in(scl_in), .sda_in(sda_in));
  // Sampling at the falling edge keeps the result clear of edge races.
  task automatic bus_wait(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (r !== 1'b1) begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    bus_wait(d);
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait(d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, a, wd, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic idle_wait;
    logic [31:0] s;
    s = 32'h8;
    while (s[`IAS_STAT_BUSY] !== 1'b0) rd(`IAS_OFF_STAT, s);
  endtask
  // Runs a sequence while the target stretches and software hits the buffer.
  task automatic run_seq(input logic [31:0] ctl, input logic [1:0] pins);
    wr(`IAS_OFF_CTRL, ctl);
    @(negedge hclk);
    `CHK({scl_oe_n, sda_oe_n}, pins)
    @(posedge hclk);
    stretch <= 1'b1;
    wr(`IAS_OFF_BUF, 32'hA5);
    repeat (12) @(posedge hclk);
    stretch <= 1'b0;
    idle_wait();
  endtask
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    hsel <= 1'b1;
    rd(`IAS_OFF_BAUD, rv);
    `CHK(rv, 32'h9)
    `CHK(hresp, 1'b0)
    wr(`IAS_OFF_BAUD, 32'h2);
    wr(`IAS_OFF_MASK, 32'h7);
    wr(`IAS_OFF_BUF, 32'h5A);
    byte_done <= 1'b1;
    @(posedge hclk);
    byte_done <= 1'b0;
    repeat (3) @(posedge hclk);
    `CHK(scl_oe_n, 1'b0)
    for (int i = 0; i < 2; i++) begin
      run_seq({29'h0, i[0], 2'b01}, {1'b0, i[0]});
      `CHK({scl_oe_n, irq}, 2'b01)
      rd(`IAS_OFF_CTRL, rv);
      `CHK(rv, {29'h0, i[0], 2'b00})
      rd(`IAS_OFF_IRQ, rv);
      `CHK(rv, 32'h3)
      rd(`IAS_OFF_BUF, rv);
      `CHK({rv, irq}, {32'h5A, 1'b0})
    end
    // Masked: the stop must leave the interrupt line quiet.
    wr(`IAS_OFF_MASK, 32'h0);
    run_seq(32'h2, 2'b00);
    `CHK({scl_oe_n, sda_oe_n, irq}, 3'b110)
    rd(`IAS_OFF_STAT, rv);
    `CHK(rv, 32'h7)
    rd(`IAS_OFF_CTRL, rv);
    `CHK(rv, 32'h0)
    rd(`IAS_OFF_IRQ, rv);
    `CHK(rv, 32'h7)
    rd(`IAS_OFF_BUF, rv);
    `CHK(rv, 32'h5A)
    rd(8'hF0, rv);
    `CHK(rv, 32'h0)
    print_verdict();
  end
endmodule
